/* File: hw/csi_pkg.sv */
// Purpose: Shared constants of the charger supervisor and interrupt block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Every offset and field position lives here, with the mask, control and current reset values
package csi_pkg;

    // --------------------
    // Register byte offsets
    // --------------------
    localparam logic [7:0] ADDR_SRC = 8'h00;
    localparam logic [7:0] ADDR_TOP = 8'h04;
    localparam logic [7:0] ADDR_CHG = 8'h08;
    localparam logic [7:0] ADDR_FG = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_CURR = 8'h18;
    localparam logic [7:0] ADDR_FGTH = 8'h1c;
    localparam logic [7:0] ADDR_STAT = 8'h20;

    // --------------------
    // Interrupt source register bits
    // --------------------
    localparam int SRC_CHG = 0;
    localparam int SRC_TOP = 1;
    localparam int SRC_FG = 2;

    // --------------------
    // Block interrupt layout and mask layout
    // --------------------
    localparam int TOP_W = 4;
    localparam int CHG_W = 2;
    localparam int FG_W = 2;
    localparam int MASK_W = TOP_W + CHG_W + FG_W;
    localparam int MASK_TOP_LSB = 0;
    localparam int MASK_CHG_LSB = 4;
    localparam int MASK_FG_LSB = 6;
    localparam logic [7:0] MASK_RST = 8'h00;

    // ------------------------------------------------------------
    // Control register bits and reset value
    // ------------------------------------------------------------
    localparam int CTRL_WIRED_SEL = 0;
    localparam int CTRL_WLESS_SEL = 1;
    localparam int CTRL_LDO_TWO_EN = 2;
    localparam int CTRL_LDO_ONE_EN = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'hb;

    // ------------------------------------------------------------
    // Current setting fields: position, width, top code, reset code
    // ------------------------------------------------------------
    localparam int FAST_LSB = 0;
    localparam int FAST_W = 6;
    localparam logic [5:0] FAST_MAX = 6'h3c;   // 3.0A at 50mA a step
    localparam logic [5:0] FAST_RST = 6'h00;
    localparam int WIRED_LSB = 8;
    localparam int WIRED_W = 7;
    localparam logic [6:0] WIRED_MAX = 7'h75;  // 100mA + 117 x 33.3mA
    localparam logic [6:0] WIRED_RST = 7'h0c;  // 500mA
    localparam int WLESS_LSB = 16;
    localparam int WLESS_W = 6;
    localparam logic [5:0] WLESS_MAX = 6'h3c;  // 60mA + 60 x 20mA
    localparam logic [5:0] WLESS_RST = 6'h16;  // 500mA

    // ------------------------------------------------------------
    // Status register bits
    // ------------------------------------------------------------
    localparam int STAT_BATT = 0;
    localparam int STAT_WIRED = 1;
    localparam int STAT_WLESS = 2;
    localparam int STAT_UVLO = 3;
    localparam int STAT_OVLO = 4;
    localparam int STAT_SWITCH = 5;
    localparam int STAT_PULLUP = 6;
    localparam int STAT_IRQ = 7;

endpackage

/* File: hw/csi_change_detect.sv */
// Purpose: One-cycle pulse on any change of each input bit
// Assumes: Inputs synchronous to clk
// Notes:   First cycle after reset compares against a zero history
`timescale 1ns/1ns
module csi_change_detect #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels in, change pulses out
    input wire logic [WIDTH-1:0] levelIn,
    output logic [WIDTH-1:0] changePulse
);

    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    // Next history value
    always_comb
    begin
        prev_d = levelIn;
    end

    // History register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            prev_q <= prev_d;
    end

    // Either edge marks a change
    assign changePulse = levelIn ^ prev_q;

endmodule // csi_change_detect

/* File: hw/csi_supervisor.sv */
// Purpose: Interrupt gathering and supervisory control of a charger companion
// Assumes: Comparator results arrive as synchronous digital levels
// Notes:   Summary of operation follows; open-drain pins drive when enable low
//
// Summary of operation
// - Pull interrupt pin low on unmasked pending
// - Source reads 0x02 for top block
// - Release pin when last pending read starts
// - Gauge interrupts clear on threshold write only
// - Mask bit blocks its interrupt from pin
// - Source shows masked interrupts too
// - Undervolt with valid input resets registers
// - Between dead level and lockout: switch closed
// - Valid input below dead level: 50mA pullup
// - No input below dead level: switch open
// - Overvolt lockout resets charger registers
// - Low detect means battery, enables charging
// - First LDO on after detection, wired valid, its enable
// - Second LDO also needs its enable
// - Input-valid flag low on valid input
// - Wireless-valid flag low on wireless valid
// - Wireless select bit gates wireless input
// - Wired select bit gates wired input
// - Fast charge code 0 to 3.0A
// - Wired limit 100mA to 4.0A, 500mA reset
// - Wireless limit 60mA to 1.26A, 500mA
`timescale 1ns/1ns
module csi_supervisor #(
    parameter int ADDR_W = 8,
    parameter int FGTH_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog comparator results
    input wire logic sysBelowUvlo,
    input wire logic sysBelowDeadBat,
    input wire logic sysAboveOvlo,
    input wire logic sysValid,
    input wire logic wiredValid,
    input wire logic wirelessValid,
    input wire logic batteryDetectN,
    input wire logic chargerDetectDone,
    // Fuel gauge threshold events
    input wire logic [1:0] fuelGaugeAlert,
    // Open-drain flags, driven low while enable is low
    output logic irqOutN,
    output logic irqOutOeN,
    output logic inputValidN,
    output logic inputValidOeN,
    output logic wirelessValidN,
    output logic wirelessValidOeN,
    // Power path controls
    output logic batterySwitchClosed,
    output logic sysPullupEn,
    output logic chargeEn,
    output logic wiredInputEn,
    output logic wirelessInputEn,
    output logic protectedLdoOneEn,
    output logic protectedLdoTwoEn,
    // Current setting codes
    output logic [5:0] fastChargeCode,
    output logic [6:0] wiredLimitCode,
    output logic [5:0] wirelessLimitCode,
    // Gauge threshold value
    output logic [FGTH_W-1:0] fuelGaugeThreshold
);

    // --------------------
    // Elaboration checks
    // --------------------
    if (ADDR_W < 6 || ADDR_W > 8)
        $error("ADDR_W must be 6 to 8");
    if (FGTH_W < 1 || FGTH_W > 32)
        $error("FGTH_W must be 1 to 32");

    // --------------------
    // Helper functions
    // --------------------

    // Merge write data into a word under byte enables
    function automatic logic [31:0] laneMerge(input logic [31:0] oldWord,
                                              input logic [31:0] newWord,
                                              input logic [3:0] sel);
        logic [31:0] merged;
        merged = oldWord;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                merged[i*8 +: 8] = newWord[i*8 +: 8];
        end
        return merged;
    endfunction

    // Limit a written code to the top of its range
    function automatic logic [7:0] clampCode(input logic [7:0] code,
                                             input logic [7:0] maxCode);
        return (code > maxCode) ? maxCode : code;
    endfunction

    // --------------------
    // State declarations
    // --------------------
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [csi_pkg::TOP_W-1:0] top_q, top_d;
    logic [csi_pkg::CHG_W-1:0] chg_q, chg_d;
    logic [csi_pkg::FG_W-1:0] fg_q, fg_d;
    logic [csi_pkg::MASK_W-1:0] mask_q, mask_d;
    logic [csi_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [5:0] fast_q, fast_d;
    logic [6:0] wired_q, wired_d;
    logic [5:0] wless_q, wless_d;
    logic [FGTH_W-1:0] fgth_q, fgth_d;
    logic irqOe_q, irqOe_d;
    logic inOkOe_q, inOkOe_d;
    logic wcOkOe_q, wcOkOe_d;
    logic switch_q, switch_d;
    logic pullup_q, pullup_d;
    logic chgEn_q, chgEn_d;
    logic ldoOne_q, ldoOne_d;
    logic ldoTwo_q, ldoTwo_d;

    // Combinational helpers
    logic reqStart, rdStart, wrStart;
    logic [7:0] addr;
    logic [31:0] wmerged;
    logic battPresent, wiredOk, wirelessOk, inputOk;
    logic wiredSysOk, wlessSysOk, eitherSysOk;
    logic lockoutReset;
    logic [5:0] statLevels, statChange;
    logic [csi_pkg::TOP_W-1:0] topEvent;
    logic [csi_pkg::CHG_W-1:0] chgEvent;
    logic [2:0] srcWord;
    logic [7:0] statWord;

    // --------------------
    // Bus decode
    // --------------------

    // A request starts in the cycle before its ack
    assign reqStart = wb_cyc_i && wb_stb_i && !ack_q;
    assign rdStart = reqStart && !wb_we_i;
    assign wrStart = reqStart && wb_we_i;
    assign addr = 8'(wb_adr_i);

    // --------------------
    // Input qualification
    // --------------------

    // Battery present on a low detect level
    assign battPresent = !batteryDetectN;
    assign wiredOk = wiredValid && ctrl_q[csi_pkg::CTRL_WIRED_SEL];
    assign wirelessOk = wirelessValid && ctrl_q[csi_pkg::CTRL_WLESS_SEL];
    assign inputOk = wiredOk || wirelessOk;
    assign wiredSysOk = wiredValid && sysValid;
    assign wlessSysOk = wirelessValid && sysValid;
    assign eitherSysOk = wiredSysOk || wlessSysOk;

    // Undervolt with a valid input, or any overvolt, clears settings
    assign lockoutReset = (inputOk && sysBelowUvlo) || sysAboveOvlo;

    // --------------------
    // Event detection
    // --------------------

    // Levels watched for status changes
    assign statLevels = {wlessSysOk, wiredSysOk, eitherSysOk, battPresent,
                         sysAboveOvlo, sysBelowUvlo};

    csi_change_detect #(
        .WIDTH(6)
    ) u_change (
        .clk(clk),
        .rst_n(rst_n),
        .levelIn(statLevels),
        .changePulse(statChange)
    );

    // Split change pulses between the two register blocks
    assign topEvent = statChange[3:0];
    assign chgEvent = statChange[5:4];

    // --------------------
    // Interrupt state
    // --------------------

    // Sticky bits; a set in the clearing cycle wins
    always_comb
    begin
        top_d = top_q;
        chg_d = chg_q;
        fg_d = fg_q;
        if (rdStart && addr == csi_pkg::ADDR_TOP)
            top_d = '0;
        if (rdStart && addr == csi_pkg::ADDR_CHG)
            chg_d = '0;
        if (wrStart && addr == csi_pkg::ADDR_FGTH)
            fg_d = '0;
        top_d = top_d | topEvent;
        chg_d = chg_d | chgEvent;
        fg_d = fg_d | fuelGaugeAlert;
    end

    // Pin drives on any unmasked pending bit, from next-state values
    always_comb
    begin
        irqOe_d = |(top_d & ~mask_q[csi_pkg::MASK_TOP_LSB +: csi_pkg::TOP_W])
            || |(chg_d & ~mask_q[csi_pkg::MASK_CHG_LSB +: csi_pkg::CHG_W])
            || |(fg_d & ~mask_q[csi_pkg::MASK_FG_LSB +: csi_pkg::FG_W]);
    end

    // Interrupt registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            top_q <= '0;
            chg_q <= '0;
            fg_q <= '0;
            irqOe_q <= 1'b0;
        end
        else
        begin
            top_q <= top_d;
            chg_q <= chg_d;
            fg_q <= fg_d;
            irqOe_q <= irqOe_d;
        end
    end

    // --------------------
    // Software settings
    // --------------------

    assign wmerged = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);

    // Writes, then lockout reset of the charger settings
    always_comb
    begin
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        fast_d = fast_q;
        wired_d = wired_q;
        wless_d = wless_q;
        fgth_d = fgth_q;
        if (wrStart)
        begin
            unique case (addr)
                csi_pkg::ADDR_MASK:
                    mask_d = 8'(laneMerge({24'h00_0000, mask_q}, wb_dat_i, wb_sel_i));
                csi_pkg::ADDR_CTRL:
                    ctrl_d = 4'(laneMerge({28'h000_0000, ctrl_q}, wb_dat_i, wb_sel_i));
                csi_pkg::ADDR_CURR:
                begin
                    if (wb_sel_i[0])
                        fast_d = 6'(clampCode({2'h0, wmerged[csi_pkg::FAST_LSB +:
                            csi_pkg::FAST_W]}, {2'h0, csi_pkg::FAST_MAX}));
                    if (wb_sel_i[1])
                        wired_d = 7'(clampCode({1'h0, wmerged[csi_pkg::WIRED_LSB +:
                            csi_pkg::WIRED_W]}, {1'h0, csi_pkg::WIRED_MAX}));
                    if (wb_sel_i[2])
                        wless_d = 6'(clampCode({2'h0, wmerged[csi_pkg::WLESS_LSB +:
                            csi_pkg::WLESS_W]}, {2'h0, csi_pkg::WLESS_MAX}));
                end
                csi_pkg::ADDR_FGTH:
                    fgth_d = FGTH_W'(laneMerge(32'(fgth_q), wb_dat_i, wb_sel_i));
                default:
                    ;
            endcase
        end
        if (lockoutReset)
        begin
            ctrl_d = csi_pkg::CTRL_RST;
            fast_d = csi_pkg::FAST_RST;
            wired_d = csi_pkg::WIRED_RST;
            wless_d = csi_pkg::WLESS_RST;
            fgth_d = '0;
        end
    end

    // Setting registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_q <= csi_pkg::MASK_RST;
            ctrl_q <= csi_pkg::CTRL_RST;
            fast_q <= csi_pkg::FAST_RST;
            wired_q <= csi_pkg::WIRED_RST;
            wless_q <= csi_pkg::WLESS_RST;
            fgth_q <= '0;
        end
        else
        begin
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
            fast_q <= fast_d;
            wired_q <= wired_d;
            wless_q <= wless_d;
            fgth_q <= fgth_d;
        end
    end

    // --------------------
    // Power path and flag outputs
    // --------------------

    // Switch, pullup, charge enable, LDOs and flag enables
    always_comb
    begin
        switch_d = 1'b1;
        pullup_d = 1'b0;
        if (sysBelowDeadBat)
        begin
            switch_d = 1'b0;
            pullup_d = inputOk;
        end
        chgEn_d = battPresent && inputOk && !lockoutReset;
        ldoOne_d = chargerDetectDone && wiredOk
            && ctrl_q[csi_pkg::CTRL_LDO_ONE_EN];
        ldoTwo_d = chargerDetectDone && wiredOk
            && ctrl_q[csi_pkg::CTRL_LDO_TWO_EN];
        inOkOe_d = !eitherSysOk;
        wcOkOe_d = !wlessSysOk;
    end

    // Power path registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            switch_q <= 1'b1;
            pullup_q <= 1'b0;
            chgEn_q <= 1'b0;
            ldoOne_q <= 1'b0;
            ldoTwo_q <= 1'b0;
            inOkOe_q <= 1'b1;
            wcOkOe_q <= 1'b1;
        end
        else
        begin
            switch_q <= switch_d;
            pullup_q <= pullup_d;
            chgEn_q <= chgEn_d;
            ldoOne_q <= ldoOne_d;
            ldoTwo_q <= ldoTwo_d;
            inOkOe_q <= inOkOe_d;
            wcOkOe_q <= wcOkOe_d;
        end
    end

    // --------------------
    // Read path
    // --------------------

    // Source shows every pending block, masked or not
    assign srcWord = {|fg_q, |top_q, |chg_q};

    // Live status word
    always_comb
    begin
        statWord = '0;
        statWord[csi_pkg::STAT_BATT] = battPresent;
        statWord[csi_pkg::STAT_WIRED] = wiredOk;
        statWord[csi_pkg::STAT_WLESS] = wirelessOk;
        statWord[csi_pkg::STAT_UVLO] = sysBelowUvlo;
        statWord[csi_pkg::STAT_OVLO] = sysAboveOvlo;
        statWord[csi_pkg::STAT_SWITCH] = switch_q;
        statWord[csi_pkg::STAT_PULLUP] = pullup_q;
        statWord[csi_pkg::STAT_IRQ] = irqOe_q;
    end

    // Read mux and single-wait-state ack
    always_comb
    begin
        ack_d = reqStart;
        rdata_d = rdata_q;
        if (rdStart)
        begin
            unique case (addr)
                csi_pkg::ADDR_SRC: rdata_d = 32'(srcWord);
                csi_pkg::ADDR_TOP: rdata_d = 32'(top_q);
                csi_pkg::ADDR_CHG: rdata_d = 32'(chg_q);
                csi_pkg::ADDR_FG: rdata_d = 32'(fg_q);
                csi_pkg::ADDR_MASK: rdata_d = 32'(mask_q);
                csi_pkg::ADDR_CTRL: rdata_d = 32'(ctrl_q);
                csi_pkg::ADDR_CURR: rdata_d = {10'h000, wless_q, 1'b0, wired_q,
                                               2'h0, fast_q};
                csi_pkg::ADDR_FGTH: rdata_d = 32'(fgth_q);
                csi_pkg::ADDR_STAT: rdata_d = 32'(statWord);
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // --------------------
    // Output mapping, all from flip-flops except the tied-low pin values
    // --------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irqOutN = 1'b0;
    assign irqOutOeN = !irqOe_q;
    assign inputValidN = 1'b0;
    assign inputValidOeN = inOkOe_q;
    assign wirelessValidN = 1'b0;
    assign wirelessValidOeN = wcOkOe_q;
    assign batterySwitchClosed = switch_q;
    assign sysPullupEn = pullup_q;
    assign chargeEn = chgEn_q;
    assign wiredInputEn = ctrl_q[csi_pkg::CTRL_WIRED_SEL];
    assign wirelessInputEn = ctrl_q[csi_pkg::CTRL_WLESS_SEL];
    assign protectedLdoOneEn = ldoOne_q;
    assign protectedLdoTwoEn = ldoTwo_q;
    assign fastChargeCode = fast_q;
    assign wiredLimitCode = wired_q;
    assign wirelessLimitCode = wless_q;
    assign fuelGaugeThreshold = fgth_q;

endmodule // csi_supervisor

/* File: test/csi_host_pins.sv */
// Purpose: Host side of the open-drain pins, with pull-ups
// Assumes: Enable low means the device pulls the line low
// Notes:   A released line reads high, never the last value
`timescale 1ns/1ns
module csi_host_pins (
    // Values and enables from the device
    input wire logic irqVal,
    input wire logic irqOeN,
    input wire logic ivVal,
    input wire logic ivOeN,
    // Resolved lines seen by the host
    output logic irqLine,
    output logic ivLine
);
    // Pull-up wins whenever the device lets go
    assign irqLine = irqOeN ? 1'b1 : irqVal;
    assign ivLine = ivOeN ? 1'b1 : ivVal;
endmodule // csi_host_pins

/* File: test/csi_monitor.sv */
// Purpose: Port assertions of the supervisor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound onto csi_supervisor below
`timescale 1ns/1ns
module csi_monitor (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Comparator levels
    input wire logic sysBelowUvlo,
    input wire logic sysBelowDeadBat,
    input wire logic sysAboveOvlo,
    input wire logic sysValid,
    input wire logic wiredValid,
    input wire logic wirelessValid,
    input wire logic batteryDetectN,
    input wire logic chargerDetectDone,
    // Device outputs
    input wire logic inputValidOeN,
    input wire logic wirelessValidOeN,
    input wire logic batterySwitchClosed,
    input wire logic sysPullupEn,
    input wire logic chargeEn,
    input wire logic wiredInputEn,
    input wire logic protectedLdoOneEn,
    input wire logic protectedLdoTwoEn,
    input wire logic [5:0] fastChargeCode,
    input wire logic [6:0] wiredLimitCode,
    input wire logic [5:0] wirelessLimitCode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Bus answer and reset-value sequences
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence s_dflt; fastChargeCode == csi_pkg::FAST_RST && wiredLimitCode ==
        csi_pkg::WIRED_RST && wirelessLimitCode == csi_pkg::WLESS_RST; endsequence
    // Properties
    property p_ack; s_req |=> s_ans; endproperty
    property p_swOn; !sysBelowDeadBat |=> batterySwitchClosed; endproperty
    property p_swOff; sysBelowDeadBat |=> !batterySwitchClosed; endproperty
    property p_noPull; sysBelowDeadBat && !wiredValid && !wirelessValid |=> !sysPullupEn;
    endproperty
    property p_pull; sysBelowDeadBat && wiredValid && wiredInputEn |=> sysPullupEn; endproperty
    property p_inok;
        1 |=> inputValidOeN == !$past(sysValid && (wiredValid || wirelessValid));
    endproperty
    property p_wcok; 1 |=> wirelessValidOeN == !$past(sysValid && wirelessValid); endproperty
    property p_ldo1; protectedLdoOneEn |-> $past(wiredValid && chargerDetectDone); endproperty
    property p_ldo2; protectedLdoTwoEn |-> $past(wiredValid && chargerDetectDone); endproperty
    property p_chg; chargeEn |-> $past(!batteryDetectN); endproperty
    property p_ovlo; sysAboveOvlo |=> s_dflt; endproperty
    property p_uvlo; sysBelowUvlo && wiredValid && wiredInputEn |=> s_dflt; endproperty
    property p_max; fastChargeCode <= csi_pkg::FAST_MAX && wiredLimitCode <=
        csi_pkg::WIRED_MAX && wirelessLimitCode <= csi_pkg::WLESS_MAX; endproperty
    a_ack: assert property (p_ack) else $error("bus ack wrong");
    a_swOn: assert property (p_swOn) else $error("switch open");
    a_swOff: assert property (p_swOff) else $error("switch closed");
    a_noPull: assert property (p_noPull) else $error("pullup on");
    a_pull: assert property (p_pull) else $error("pullup off");
    a_inok: assert property (p_inok) else $error("input flag wrong");
    a_wcok: assert property (p_wcok) else $error("wireless flag wrong");
    a_ldo1: assert property (p_ldo1) else $error("ldo one early");
    a_ldo2: assert property (p_ldo2) else $error("ldo two early");
    a_chg: assert property (p_chg) else $error("charge without battery");
    a_ovlo: assert property (p_ovlo) else $error("overvolt kept codes");
    a_uvlo: assert property (p_uvlo) else $error("undervolt kept codes");
    a_max: assert property (p_max) else $error("code above top");
endmodule // csi_monitor
bind csi_supervisor csi_monitor mon (.*);

/* File: test/charger_supervisor_irq_bench.sv */
// Purpose: Self-checking bench of the supervisor
// Assumes: Registers over classic Wishbone, one 250 MHz clock
// Notes:   Random codes and levels come from a fixed-seed shift register
`timescale 1ns/1ns
module charger_supervisor_irq_bench;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, uv = 0, ov = 0, dead = 0;
    logic sysOk = 0, wiOk = 0, wlOk = 0, batN = 1, done = 0, irqV, irqOe, irqW, ivV, ivOe;
    logic ivW, wvV, wvOe, sw, pu, ce, wiEn, wlEn, l1, l2;
    logic [1:0] fga = 2'h0;
    logic [5:0] fc, wlc;
    logic [6:0] wic;
    logic [7:0] adr = 8'h00;
    logic [15:0] th, lf = 16'ha493;
    logic [31:0] wd = 32'h0, rdat, q, e;
    int errTotal = 0, testsRun = 0, cycles = 0;
    // Design, host pins
    csi_supervisor uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sysBelowUvlo(uv), .sysBelowDeadBat(dead), .sysAboveOvlo(ov), .sysValid(sysOk),
        .wiredValid(wiOk), .wirelessValid(wlOk), .batteryDetectN(batN),
        .chargerDetectDone(done), .fuelGaugeAlert(fga), .irqOutN(irqV), .irqOutOeN(irqOe),
        .inputValidN(ivV), .inputValidOeN(ivOe), .wirelessValidN(wvV), .wirelessValidOeN(wvOe),
        .batterySwitchClosed(sw), .sysPullupEn(pu), .chargeEn(ce), .wiredInputEn(wiEn),
        .wirelessInputEn(wlEn), .protectedLdoOneEn(l1), .protectedLdoTwoEn(l2),
        .fastChargeCode(fc), .wiredLimitCode(wic), .wirelessLimitCode(wlc),
        .fuelGaugeThreshold(th));
    csi_host_pins host (.irqVal(irqV), .irqOeN(irqOe), .ivVal(ivV), .ivOeN(ivOe),
        .irqLine(irqW), .ivLine(ivW));
    // Clock
    initial forever #2 clk = ~clk;
    // Hang guard
    always @(posedge clk)
    begin
        if (++cycles == 20000)
        begin
            errTotal++;
            printVerdict();
        end
    end
    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected setting word after clamping
    function automatic logic [31:0] clamp(logic [31:0] v);
        logic [5:0] f, l;
        logic [6:0] w;
        f = (v[5:0] > csi_pkg::FAST_MAX) ? csi_pkg::FAST_MAX : v[5:0];
        w = (v[14:8] > csi_pkg::WIRED_MAX) ? csi_pkg::WIRED_MAX : v[14:8];
        l = (v[21:16] > csi_pkg::WLESS_MAX) ? csi_pkg::WLESS_MAX : v[21:16];
        return {10'h0, l, 1'b0, w, 2'h0, f};
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        testsRun++;
        if (g !== x)
        begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask
    task automatic pin(input logic x, input int c);
        repeat (c) @(posedge clk);
        chk("irq pin", {31'h0, x}, {31'h0, irqW});
    endtask
    task automatic printVerdict();
        if (errTotal == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdChk("ctrl", csi_pkg::ADDR_CTRL, 32'hb);
        rdChk("curr", csi_pkg::ADDR_CURR, 32'h00160c00);
        rdChk("mask", csi_pkg::ADDR_MASK, 32'h0);
        rdChk("unmapped", 8'h24, 32'h0);
        bus(1'b0, csi_pkg::ADDR_TOP, 32'h0);
        bus(1'b0, csi_pkg::ADDR_CHG, 32'h0);
        batN <= 1'b0;
        pin(1'b0, 8);
        rdChk("source", csi_pkg::ADDR_SRC, 32'h2);
        rdChk("top", csi_pkg::ADDR_TOP, 32'h4);
        pin(1'b1, 1);
        bus(1'b1, csi_pkg::ADDR_MASK, 32'h0f);
        uv <= 1'b1;
        wiOk <= 1'b1;
        repeat (2) @(posedge clk);
        uv <= 1'b0;
        wiOk <= 1'b0;
        pin(1'b1, 4);
        rdChk("masked src", csi_pkg::ADDR_SRC, 32'h2);
        rdChk("top", csi_pkg::ADDR_TOP, 32'h1);
        bus(1'b1, csi_pkg::ADDR_MASK, 32'h0);
        fga <= 2'h2;
        @(posedge clk);
        fga <= 2'h0;
        pin(1'b0, 4);
        rdChk("fg", csi_pkg::ADDR_FG, 32'h2);
        rdChk("fg again", csi_pkg::ADDR_FG, 32'h2);
        bus(1'b1, csi_pkg::ADDR_FGTH, {16'h0, lf});
        chk("thresh", {16'h0, lf}, {16'h0, th});
        rdChk("fg clear", csi_pkg::ADDR_FG, 32'h0);
        pin(1'b1, 1);
        for (int i = 0; i < 8; i++)
        begin
            lf = nxt(lf);
            e = (i == 0) ? 32'hffffffff : {lf, nxt(nxt(lf))};
            bus(1'b1, csi_pkg::ADDR_CURR, e);
            rdChk("curr", csi_pkg::ADDR_CURR, clamp(e));
        end
        ov <= 1'b1;
        @(posedge clk);
        ov <= 1'b0;
        rdChk("curr ovlo", csi_pkg::ADDR_CURR, 32'h00160c00);
        bus(1'b1, csi_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("input en", 32'h0, {30'h0, wiEn, wlEn});
        bus(1'b1, csi_pkg::ADDR_CTRL, 32'hf);
        repeat (2) @(posedge clk);
        chk("input en", 32'h3, {30'h0, wiEn, wlEn});
        repeat (96)
        begin
            @(posedge clk);
            lf = nxt(lf);
            {sysOk, wiOk, wlOk, dead, done, batN} <= lf[5:0];
        end
        printVerdict();
    end
endmodule // charger_supervisor_irq_bench
